/* design/umh_modem_handshake.sv */
// Purpose: modem handshake outputs, modem status and interrupt
// Assumes: single clock core_clk, transmitter busy comes from
//          logic on the same clock
// Notes:   register data are 8 bits; read data stand one cycle
`timescale 1ns/1ps
module umh_modem_handshake (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // interrupt
    output logic            irq,
    // modem lines
    input  wire logic       clear_to_send_in_n,
    input  wire logic       set_ready_in_n,
    input  wire logic       ring_indicator_in_n,
    input  wire logic       carrier_detect_in_n,
    output logic            request_to_send_out_n,
    output logic            terminal_ready_out_n,
    // transmitter status
    input  wire logic       tx_busy_in,
    output logic            tx_active_out
);

    // address match, used by all four strobes
    function automatic logic umh_hit(
        input logic [2:0] addr,
        input logic [2:0] target
    );
        umh_hit = (addr == target);
    endfunction : umh_hit

    // register state
    logic [7:0] modem_control_reg_r;
    logic [7:0] int_mask_r;
    logic [7:0] int_stat_r;
    logic [7:0] int_stat_nxt;
    logic [3:0] delta_r;
    logic [3:0] delta_nxt;
    logic [3:0] line_prev_n_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // output flops
    logic       rts_n_r;
    logic       dtr_n_r;
    logic       tx_active_r;
    logic       tx_busy_prev_r;

    // decoded strobes
    logic       wr_ctrl;
    logic       wr_mask;
    logic       wr_stat;
    logic       rd_modem_stat;

    // line levels
    logic [3:0] pin_raw_n;
    logic [3:0] pin_sync_n;
    logic [3:0] loop_src_n;
    logic [3:0] line_n;
    logic [3:0] delta_set;
    logic       loop_mode;
    logic       modem_event;
    logic       ring_fall;
    logic       tx_done_event;

    // strobe decode
    assign wr_ctrl       = reg_wr & umh_hit(reg_addr, umh_pkg::ADDR_MODEM_CTRL);
    assign wr_mask       = reg_wr & umh_hit(reg_addr, umh_pkg::ADDR_INT_MASK);
    assign wr_stat       = reg_wr & umh_hit(reg_addr, umh_pkg::ADDR_INT_STAT);
    assign rd_modem_stat = reg_rd & umh_hit(reg_addr, umh_pkg::ADDR_MODEM_STAT);

    assign loop_mode = modem_control_reg_r[umh_pkg::MC_LOOP_BIT];

    // modem pins in status order: cts, dsr, ri, dcd
    assign pin_raw_n = {
        carrier_detect_in_n,
        ring_indicator_in_n,
        set_ready_in_n,
        clear_to_send_in_n
    };

    // pins cross into core_clk through three flops
    umh_sync3 #(
        .WIDTH    (4),
        .IDLE_VAL (umh_pkg::LINE_IDLE_N)
    ) u_sync (
        .core_clk   (core_clk),
        .reset      (reset),
        .async_in   (pin_raw_n),
        .stable_out (pin_sync_n)
    );

    // loopback feeds control bits back as line levels
    assign loop_src_n = ~{
        modem_control_reg_r[umh_pkg::MC_OUT2_BIT],
        modem_control_reg_r[umh_pkg::MC_OUT1_BIT],
        modem_control_reg_r[umh_pkg::MC_DTR_BIT],
        modem_control_reg_r[umh_pkg::MC_RTS_BIT]
    };

    // pins are cut off from status in loopback
    assign line_n = loop_mode ? loop_src_n : pin_sync_n;

    // previous line levels for change detection
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            line_prev_n_r <= umh_pkg::LINE_IDLE_N;
        end else begin
            line_prev_n_r <= line_n;
        end
    end

    // per-line change events
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_delta
            if (gi == umh_pkg::MS_RI_IDX) begin : g_ri
                // ring flags only the input going low to high
                assign delta_set[gi] = line_n[gi] & ~line_prev_n_r[gi];
            end else begin : g_any
                // any level change counts
                assign delta_set[gi] = line_n[gi] ^ line_prev_n_r[gi];
            end
        end
    endgenerate

    // ring interrupts on either edge but flags only its rise
    assign ring_fall   = ~line_n[umh_pkg::MS_RI_IDX] & line_prev_n_r[umh_pkg::MS_RI_IDX];
    assign modem_event = (|delta_set) | ring_fall;

    // change flags; a new event wins over the read clear
    always_comb begin
        delta_nxt = delta_r;
        if (rd_modem_stat) begin
            delta_nxt = 4'h0;
        end
        delta_nxt = delta_nxt | delta_set;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            delta_r <= 4'h0;
        end else begin
            delta_r <= delta_nxt;
        end
    end

    // modem control register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            modem_control_reg_r <= umh_pkg::MODEM_CTRL_RST;
        end else if (wr_ctrl) begin
            modem_control_reg_r <= reg_wdata & umh_pkg::MC_WR_MASK;
        end
    end

    // interrupt mask register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            int_mask_r <= umh_pkg::INT_MASK_RST;
        end else if (wr_mask) begin
            int_mask_r <= reg_wdata & umh_pkg::INT_WR_MASK;
        end
    end

    // end of a transmission, seen on busy falling
    assign tx_done_event = tx_busy_prev_r & ~tx_busy_in;

    // sticky status: write one to clear, set wins over clear
    always_comb begin
        int_stat_nxt = int_stat_r;
        if (wr_stat) begin
            int_stat_nxt = int_stat_nxt & ~(reg_wdata & umh_pkg::INT_WR_MASK);
        end
        if (rd_modem_stat) begin
            int_stat_nxt[umh_pkg::INT_MODEM_BIT] = 1'b0;
        end
        if (modem_event) begin
            int_stat_nxt[umh_pkg::INT_MODEM_BIT] = 1'b1;
        end
        if (tx_done_event) begin
            int_stat_nxt[umh_pkg::INT_TX_DONE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            int_stat_r <= umh_pkg::INT_STAT_RST;
        end else begin
            int_stat_r <= int_stat_nxt;
        end
    end

    // level interrupt from unmasked status
    assign irq = |(int_stat_r & int_mask_r);

    // handshake outputs, inactive high at reset and in loopback
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rts_n_r <= 1'b1;
            dtr_n_r <= 1'b1;
        end else begin
            rts_n_r <= ~(modem_control_reg_r[umh_pkg::MC_RTS_BIT] & ~loop_mode);
            dtr_n_r <= ~(modem_control_reg_r[umh_pkg::MC_DTR_BIT] & ~loop_mode);
        end
    end

    assign request_to_send_out_n = rts_n_r;
    assign terminal_ready_out_n  = dtr_n_r;

    // transmit activity follows busy only, never clear-to-send
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_active_r    <= 1'b0;
            tx_busy_prev_r <= 1'b0;
        end else begin
            tx_active_r    <= tx_busy_in;
            tx_busy_prev_r <= tx_busy_in;
        end
    end

    assign tx_active_out = tx_active_r;

    // read mux; zero outside a read and on unmapped offsets
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                umh_pkg::ADDR_MODEM_CTRL: rdata_nxt = modem_control_reg_r;
                umh_pkg::ADDR_INT_MASK:   rdata_nxt = int_mask_r;
                umh_pkg::ADDR_INT_STAT:   rdata_nxt = int_stat_r;
                umh_pkg::ADDR_MODEM_STAT: begin
                    rdata_nxt[umh_pkg::MS_LEVEL_LSB +: 4] = ~line_n;
                    rdata_nxt[umh_pkg::MS_DELTA_LSB +: 4] = delta_r;
                end
                umh_pkg::ADDR_TX_STAT:    rdata_nxt = {7'h00, tx_active_r};
                default:                  rdata_nxt = 8'h00;
            endcase
        end
    end

    // read data register
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

endmodule : umh_modem_handshake

/* design/umh_pkg.sv */
// Purpose: constants shared by the modem handshake block
// Assumes: 8-bit register data, 3-bit register address
// Notes:   offsets are word indices of the plain register port
package umh_pkg;

    // register offsets
    localparam logic [2:0] ADDR_INT_MASK   = 3'h1;
    localparam logic [2:0] ADDR_INT_STAT   = 3'h2;
    localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
    localparam logic [2:0] ADDR_MODEM_STAT = 3'h6;
    localparam logic [2:0] ADDR_TX_STAT    = 3'h7;

    // modem control fields
    localparam int MC_DTR_BIT  = 0;
    localparam int MC_RTS_BIT  = 1;
    localparam int MC_OUT1_BIT = 2;
    localparam int MC_OUT2_BIT = 3;
    localparam int MC_LOOP_BIT = 4;
    localparam logic [7:0] MC_WR_MASK = 8'h1F;

    // modem status fields: change flags low, levels high
    localparam int MS_DELTA_LSB = 0;
    localparam int MS_LEVEL_LSB = 4;
    localparam int MS_RI_IDX    = 2;

    // interrupt status and mask fields
    localparam int INT_TX_DONE_BIT = 0;
    localparam int INT_MODEM_BIT   = 3;
    localparam logic [7:0] INT_WR_MASK = 8'h09;

    // reset values
    localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
    localparam logic [7:0] INT_MASK_RST   = 8'h00;
    localparam logic [7:0] INT_STAT_RST   = 8'h00;
    localparam logic [3:0] LINE_IDLE_N    = 4'hF;

    // input synchroniser depth
    localparam int SYNC_STAGES = 3;

endpackage : umh_pkg

/* design/umh_sync3.sv */
// Purpose: three-flop synchroniser with agreement filter
// Assumes: inputs idle high, asynchronous to core_clk
// Notes:   the output moves only when stages two and three agree
`timescale 1ns/1ps
module umh_sync3 #(
    parameter int          WIDTH    = 4,
    parameter logic [3:0]  IDLE_VAL = 4'hF
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // asynchronous input and filtered output
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] stable_out
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] stable_r;

    // shift chain; stage1 feeds only stage2
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1_r <= IDLE_VAL[WIDTH-1:0];
            stage2_r <= IDLE_VAL[WIDTH-1:0];
            stage3_r <= IDLE_VAL[WIDTH-1:0];
        end else begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // accept a bit once stages two and three agree
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stable_r <= IDLE_VAL[WIDTH-1:0];
        end else begin
            stable_r <= (stage2_r & stage3_r) | (stable_r & (stage2_r ^ stage3_r));
        end
    end

    assign stable_out = stable_r;

endmodule : umh_sync3

/* dv/umh_props.sv */
// Purpose: port checks for the modem handshake block
// Assumes: register offsets of umh_pkg
// Notes:   shadows track loopback, mask and quiet time on the pins
`timescale 1ns/1ps
module umh_props (
    // clock, reset and register port
    input logic       core_clk,
    input logic       reset,
    input logic [2:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_rdata,
    input logic       irq,
    // modem lines
    input logic       clear_to_send_in_n,
    input logic       set_ready_in_n,
    input logic       ring_indicator_in_n,
    input logic       carrier_detect_in_n,
    input logic       request_to_send_out_n,
    input logic       terminal_ready_out_n,
    // transmitter
    input logic       tx_busy_in,
    input logic       tx_active_out
);
    logic [3:0] pins;
    logic [3:0] pins_q;
    logic [3:0] quiet_r;
    logic [1:0] mask_r;
    logic       loop_r;
    logic       mc_wr;
    logic       ms_rd;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // pins in status order, strobes of interest
    assign pins  = {carrier_detect_in_n, ring_indicator_in_n, set_ready_in_n, clear_to_send_in_n};
    assign mc_wr = reg_wr && reg_addr == umh_pkg::ADDR_MODEM_CTRL;
    assign ms_rd = reg_rd && reg_addr == umh_pkg::ADDR_MODEM_STAT && !loop_r && quiet_r > 4'h7;
    // loopback and mask shadows, cycles since a pin or control change
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            loop_r  <= 1'b0;
            mask_r  <= 2'h0;
            quiet_r <= 4'h0;
            pins_q  <= 4'hF;
        end else begin
            if (mc_wr) loop_r <= reg_wdata[4];
            if (reg_wr && reg_addr == umh_pkg::ADDR_INT_MASK) mask_r <= {reg_wdata[3], reg_wdata[0]};
            quiet_r <= (mc_wr || pins != pins_q) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
            pins_q  <= pins;
        end
    end
    property p_rst;
        disable iff (1'b0) reset |-> request_to_send_out_n && terminal_ready_out_n && !irq && !tx_active_out;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle in reset");
    property p_rts; mc_wr && !reg_wdata[4] |-> ##2 request_to_send_out_n == !$past(reg_wdata[1], 2); endproperty
    a_rts: assert property (p_rts) else $error("request pin not from control");
    property p_dtr; mc_wr && !reg_wdata[4] |-> ##2 terminal_ready_out_n == !$past(reg_wdata[0], 2); endproperty
    a_dtr: assert property (p_dtr) else $error("ready pin not from control");
    property p_loop; mc_wr && reg_wdata[4] |-> ##2 request_to_send_out_n && terminal_ready_out_n; endproperty
    a_loop: assert property (p_loop) else $error("pins active in loopback");
    property p_tx; 1'b1 |=> tx_active_out == $past(tx_busy_in); endproperty
    a_tx: assert property (p_tx) else $error("tx activity wrong");
    property p_lvl; ms_rd |=> reg_rdata[7:4] == ~$past(pins); endproperty
    a_lvl: assert property (p_lvl) else $error("status levels wrong");
    property p_chg;
        !loop_r && mask_r[1] && $changed(pins) |-> ##[1:8] irq;
    endproperty
    a_chg: assert property (p_chg) else $error("no interrupt on change");
    property p_clr; ms_rd && !mask_r[0] |=> !irq; endproperty
    a_clr: assert property (p_clr) else $error("status read left interrupt");
    // main scenarios reached
    cover property (irq && mask_r[1]);
    cover property (ms_rd ##1 reg_rdata[3:0] != 4'h0);
    cover property (mc_wr && reg_wdata[4]);
endmodule : umh_props

bind umh_modem_handshake umh_props i_umh_props (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq, .clear_to_send_in_n, .set_ready_in_n, .ring_indicator_in_n, .carrier_detect_in_n,
    .request_to_send_out_n, .terminal_ready_out_n, .tx_busy_in, .tx_active_out);

/* dv/umh_modem_model.sv */
// Purpose: far-end modem driving the four status lines
// Assumes: modem answers request-to-send and terminal-ready
// Notes:   slow answers eight cycles late instead of one
`timescale 1ns/1ps
module umh_modem_model (
    // clock, reset and bench control
    input  logic core_clk,
    input  logic reset,
    input  logic slow,
    input  logic ring_cmd_n,
    input  logic carrier_cmd_n,
    // lines from and to the block
    input  logic request_to_send_out_n,
    input  logic terminal_ready_out_n,
    output logic clear_to_send_in_n,
    output logic set_ready_in_n,
    output logic ring_indicator_in_n,
    output logic carrier_detect_in_n
);
    logic [7:0] rts_h_r;
    logic [7:0] dtr_h_r;
    // history of the handshake outputs
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rts_h_r <= 8'hFF;
            dtr_h_r <= 8'hFF;
        end else begin
            rts_h_r <= {rts_h_r[6:0], request_to_send_out_n};
            dtr_h_r <= {dtr_h_r[6:0], terminal_ready_out_n};
        end
    end
    // answer promptly or late, ring and carrier on command
    assign clear_to_send_in_n  = slow ? rts_h_r[7] : rts_h_r[0];
    assign set_ready_in_n      = slow ? dtr_h_r[7] : dtr_h_r[0];
    assign ring_indicator_in_n = ring_cmd_n;
    assign carrier_detect_in_n = carrier_cmd_n;
endmodule : umh_modem_model

/* dv/umh_modem_handshake_tb_top.sv */
// Purpose: register and pin bench for the modem handshake block
// Assumes: modem model on the line side
// Notes:   waits of 20 cycles cover input filter and slow modem
`timescale 1ns/1ps
module umh_modem_handshake_tb_top;
    logic       core_clk = 1'b0;
    logic       reset, reg_wr, reg_rd, tx_busy_in, slow, ring_cmd_n, carrier_cmd_n;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       irq, clear_to_send_in_n, set_ready_in_n, ring_indicator_in_n, carrier_detect_in_n;
    logic       request_to_send_out_n, terminal_ready_out_n, tx_active_out;
    int         fail_count = 0;
    int         n_tests = 0;
    int         cyc = 0;
    umh_modem_handshake i_umh_modem_handshake (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .clear_to_send_in_n, .set_ready_in_n, .ring_indicator_in_n, .carrier_detect_in_n,
        .request_to_send_out_n, .terminal_ready_out_n, .tx_busy_in, .tx_active_out);
    umh_modem_model i_umh_modem_model (.core_clk, .reset, .slow, .ring_cmd_n, .carrier_cmd_n,
        .request_to_send_out_n, .terminal_ready_out_n, .clear_to_send_in_n, .set_ready_in_n,
        .ring_indicator_in_n, .carrier_detect_in_n);
    // clock and hang guard
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // irq, tx active, ready and request pins, settled after an edge
    task automatic look(input logic [3:0] e);
        #1;
        chk({4'h0, irq, tx_active_out, terminal_ready_out_n, request_to_send_out_n}, {4'h0, e});
        @(posedge core_clk);
    endtask : look
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
        @(posedge core_clk);
    endtask : rd
    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    initial begin
        reset <= 1'b1;
        {reg_wr, reg_rd, tx_busy_in, slow} <= 4'h0;
        {ring_cmd_n, carrier_cmd_n} <= 2'h3;
        {reg_addr, reg_wdata} <= 11'h000;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        // idle state, then tx activity while clear-to-send is inactive
        look(4'b0011);
        rd(umh_pkg::ADDR_MODEM_STAT, 8'h00);
        rd(3'h5, 8'h00);
        tx_busy_in <= 1'b1;
        look(4'b0011);
        look(4'b0111);
        rd(umh_pkg::ADDR_TX_STAT, 8'h01);
        tx_busy_in <= 1'b0;
        look(4'b0111);
        look(4'b0011);
        rd(umh_pkg::ADDR_INT_STAT, 8'h01);
        wr(umh_pkg::ADDR_INT_MASK, 8'h01);
        look(4'b1011);
        rd(umh_pkg::ADDR_INT_MASK, 8'h01);
        wr(umh_pkg::ADDR_INT_STAT, 8'h01);
        rd(umh_pkg::ADDR_INT_STAT, 8'h00);
        look(4'b0011);
        // slow modem answers the handshake, change raises the interrupt
        wr(umh_pkg::ADDR_INT_MASK, 8'h08);
        slow <= 1'b1;
        wr(umh_pkg::ADDR_MODEM_CTRL, 8'h03);
        look(4'b0000);
        repeat (20) @(posedge core_clk);
        look(4'b1000);
        rd(umh_pkg::ADDR_MODEM_STAT, 8'h33);
        look(4'b0000);
        rd(umh_pkg::ADDR_MODEM_STAT, 8'h30);
        // ring falls with no flag, carrier flags, ring rise flags
        {slow, ring_cmd_n, carrier_cmd_n} <= 3'h0;
        repeat (20) @(posedge core_clk);
        look(4'b1000);
        rd(umh_pkg::ADDR_MODEM_STAT, 8'hF8);
        ring_cmd_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        look(4'b1000);
        rd(umh_pkg::ADDR_MODEM_STAT, 8'hB4);
        // ring falling interrupts without a flag
        ring_cmd_n <= 1'b0;
        repeat (20) @(posedge core_clk);
        look(4'b1000);
        rd(umh_pkg::ADDR_MODEM_STAT, 8'hF0);
        look(4'b0000);
        // loopback: pins inactive, status from control, pins ignored
        wr(umh_pkg::ADDR_INT_MASK, 8'h00);
        wr(umh_pkg::ADDR_MODEM_CTRL, 8'h1F);
        look(4'b0011);
        repeat (20) @(posedge core_clk);
        rd(umh_pkg::ADDR_MODEM_STAT, 8'hF0, 8'hF0);
        carrier_cmd_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        rd(umh_pkg::ADDR_MODEM_STAT, 8'hF0);
        wr(umh_pkg::ADDR_MODEM_CTRL, 8'h00);
        look(4'b0011);
        repeat (20) @(posedge core_clk);
        rd(umh_pkg::ADDR_MODEM_STAT, 8'h40, 8'hF0);
        // request active, then a reset in mid-run
        wr(umh_pkg::ADDR_MODEM_CTRL, 8'h02);
        look(4'b0010);
        reset <= 1'b1;
        look(4'b0011);
        reset <= 1'b0;
        @(posedge core_clk);
        rd(umh_pkg::ADDR_MODEM_CTRL, 8'h00);
        conclude();
    end
endmodule : umh_modem_handshake_tb_top
